// file: logic/sbeu_count_unit.sv
// sbeu_count_unit: per-channel count condition ahead of the sequencer
`timescale 1ns/1ps
`default_nettype none
module sbeu_count_unit import sbeu_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // channel path
   sbeu_qual_if.unit q
);
   genvar g;
   for (g = 0; g < NUM_CH; g++) begin : g_ch
      if (HAS_COUNT[g]) begin : g_cnt
         logic [CNT_W-1:0] cnt_reg;
         logic [CNT_W-1:0] cnt_next;
         wire logic last;
         // a target of zero behaves as one
         assign last = (q.target[g] == '0) || (cnt_reg == q.target[g] - CNT_W'(1));
         assign q.hit[g] = q.raw[g] & last;
         // a match in the clearing cycle still counts
         assign cnt_next = (q.raw[g] && !last) ? (q.clear ? CNT_W'(1) : cnt_reg + CNT_W'(1))
                         : ((q.clear || q.raw[g]) ? '0 : cnt_reg);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_reg <= '0;
            end else begin
               cnt_reg <= cnt_next;
            end
         end
      end else begin : g_pass
         assign q.hit[g] = q.raw[g];
      end
   end
endmodule // sbeu_count_unit
`default_nettype wire

// file: logic/sbeu_pkg.sv
// sbeu_pkg: register map, field layout, mode tables and helpers for the event unit
package sbeu_pkg;
   localparam int NUM_CH = 12;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam int NUM_WREG = 8;
   localparam int PRED_W = 4;
   localparam int FACT_W = 2;

   // byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BRK_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TRC_EN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PERF = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRED_LO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PRED_HI = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_FLAG_ACT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

   // register indices
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_BRK_EN = 3'h1;
   localparam logic [2:0] IDX_TRC_EN = 3'h2;
   localparam logic [2:0] IDX_PERF = 3'h3;
   localparam logic [2:0] IDX_PRED_LO = 3'h4;
   localparam logic [2:0] IDX_PRED_HI = 3'h5;
   localparam logic [2:0] IDX_FLAG_ACT = 3'h6;
   localparam logic [2:0] IDX_COUNT = 3'h7;

   localparam logic [31:0] REG_WMASK [NUM_WREG] = '{
      32'h0000_003F, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0FFF_0FFF,
      32'hFFFF_FFFF, 32'h0000_FFFF, 32'h00FF_FFFF, 32'hFFFF_FFFF};
   localparam logic [31:0] REG_RESET [NUM_WREG] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   // field positions
   localparam int CTRL_CPU_LSB = 0;
   localparam int CTRL_SYS_LSB = 4;
   localparam int PERF_STOP_LSB = 16;
   localparam int COUNT_CH11_LSB = 16;
   localparam int STAT_FLAG_BIT = 16;
   localparam int STAT_STAGE_LSB = 20;
   localparam int STAT_SYS_ARMED_BIT = 24;

   // per-channel capabilities, bit 0 is channel 1
   localparam logic [NUM_CH-1:0] ACT_B_OK = 12'hFFF;
   localparam logic [NUM_CH-1:0] ACT_T_OK = 12'h9B0;
   localparam logic [NUM_CH-1:0] ACT_P_OK = 12'hFBF;
   localparam logic [NUM_CH-1:0] BRK_FIXED = 12'h040;
   localparam logic [NUM_CH-1:0] HAS_COUNT = 12'h402;
   localparam logic [NUM_CH-1:0] CPU_CH_MASK = 12'hE3F;
   localparam logic [NUM_CH-1:0] SYS_CH_MASK = 12'h180;
   localparam int CNT_CH_A = 1;
   localparam int CNT_CH_B = 10;
   localparam int SYS_CH8 = 7;
   localparam int SYS_CH9 = 8;

   // predecessor codes: 0 none, 1..12 channel, F shared match flag
   localparam logic [PRED_W-1:0] PRED_NONE = 4'h0;
   localparam logic [PRED_W-1:0] PRED_FLAG = 4'hF;
   localparam logic [FACT_W-1:0] FACT_SET = 2'h1;
   localparam logic [FACT_W-1:0] FACT_CLR = 2'h2;
   localparam logic FLAG_INIT = 1'b0;

   // processor chain modes
   localparam logic [3:0] CPU_MODE_OFF = 4'h0;
   localparam logic [3:0] CPU_MODE_LAST_FIXED = 4'hA;
   localparam logic [3:0] CPU_MODE_FREE = 4'hB;

   // stage channel numbers, first stage in the low nibble
   localparam logic [31:0] CPU_SEQ_TAB [16] = '{
      32'h0000_0000, 32'h0000_0012, 32'h0000_0034, 32'h0000_0056,
      32'h0000_00AB, 32'h0000_0123, 32'h0000_1234, 32'h0001_2345,
      32'h0012_3456, 32'h0123_456A, 32'h1234_56AB, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   localparam logic [3:0] CPU_SEQ_LEN [16] = '{
      4'h0, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5,
      4'h6, 4'h7, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

   typedef enum logic [1:0] {
      SYS_OFF = 2'h0,
      SYS_9_THEN_8 = 2'h1,
      SYS_8_THEN_9 = 2'h2,
      SYS_FREE = 2'h3
   } sbeu_sys_mode_t;

   function automatic logic [NUM_CH-1:0] sbeu_members(input logic [31:0] tab);
      logic [NUM_CH-1:0] m;
      m = '0;
      for (int k = 0; k < 8; k++) begin
         if (tab[k*4 +: 4] != 4'h0) begin
            m[tab[k*4 +: 4] - 4'h1] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [31:0] sbeu_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// file: logic/sbeu_qual_if.sv
// sbeu_qual_if: raw channel matches in, counted channel hits out
`timescale 1ns/1ps
`default_nettype none
interface sbeu_qual_if import sbeu_pkg::*; ();
   logic [NUM_CH-1:0] raw;
   logic [NUM_CH-1:0] hit;
   logic clear;
   logic [NUM_CH-1:0][CNT_W-1:0] target;
   modport unit (input raw, input clear, input target, output hit);
   modport core (output raw, output clear, output target, input hit);
endinterface
`default_nettype wire

// file: logic/sbeu_top.sv
// sbeu_top: sequential break and event unit with an axi4-lite register slave
// Overview of operation
// - action B breaks, T traces, per channel
// - action P starts or stops performance measurement
// - pair mode breaks on channel 2 then 1
// - pair mode breaks on channel 4 then 3
// - pair mode breaks on channel 6 then 5
// - pair mode breaks on channel 11 then 10
// - chain 3, 2, 1 breaks in order only
// - chain 4, 3, 2, 1 in order only
// - chains 5..1 and 6..1 in order only
// - chain 10, 6..1 with no stage skipped
// - chain 11, 10, 6..1 in order only
// - system bus 9 then 8 breaks
// - system bus 8 then 9 breaks
// - free processor sequencing through predecessor selects
// - free system bus sequencing through predecessor selects
// - satisfied once the selected predecessor or flag is seen, or at once with no predecessor selected
// - a predecessor channel in free sequencing never breaks itself
// - channels set or clear flag; break reinitialises
// - count channels break after programmed match count
`timescale 1ns/1ps
`default_nettype none
module sbeu_top import sbeu_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // comparator matches and outside halts
   input wire logic [NUM_CH-1:0] ch_match,
   input wire logic core_halt,
   // actions
   output logic brk_req,
   output logic [NUM_CH-1:0] trace_req,
   output logic perf_start,
   output logic perf_stop
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus slave state
   logic aw_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_full_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] wreg_q [NUM_WREG];

   // sequencer state
   logic [3:0] stage_reg;
   logic [3:0] stage_next;
   logic sys_armed_reg;
   logic sys_armed_next;
   logic [NUM_CH-1:0] seen_reg;
   logic [NUM_CH-1:0] seen_next;
   logic flag_reg;
   logic flag_next;
   logic brk_reg;
   logic [NUM_CH-1:0] trace_reg;
   logic perf_start_reg;
   logic perf_stop_reg;

   // write path decode
   wire logic do_write;
   wire logic [2:0] wr_idx;
   wire logic wr_mapped;
   wire logic wr_status;
   wire logic ctrl_written;
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready = !w_full_reg && !bvalid_reg;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_idx = aw_addr_reg[4:2];
   assign wr_mapped = (aw_addr_reg[ADDR_W-1:2] < OFS_STATUS[ADDR_W-1:2]);
   assign wr_status = (aw_addr_reg[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]);
   assign ctrl_written = do_write && wr_mapped && (wr_idx == IDX_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_full_reg <= 1'b0;
      end
   end

   // status is read only: writes to it are accepted and dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_mapped || wr_status) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   genvar g;
   genvar j;
   for (g = 0; g < NUM_WREG; g++) begin : g_wreg
      wire logic sel = do_write && wr_mapped && (wr_idx == 3'(g));
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            wreg_q[g] <= REG_RESET[g];
         end else if (sel) begin
            wreg_q[g] <= sbeu_merge(wreg_q[g], w_data_reg, w_strb_reg) & REG_WMASK[g];
         end
      end
   end

   // configuration fields
   wire logic [3:0] cpu_mode = wreg_q[IDX_CTRL][CTRL_CPU_LSB +: 4];
   wire logic [1:0] sys_mode = wreg_q[IDX_CTRL][CTRL_SYS_LSB +: 2];
   wire logic [NUM_CH-1:0] brk_eff = (wreg_q[IDX_BRK_EN][NUM_CH-1:0] & ACT_B_OK) | BRK_FIXED;
   wire logic [NUM_CH-1:0] trc_eff = wreg_q[IDX_TRC_EN][NUM_CH-1:0] & ACT_T_OK;
   wire logic [NUM_CH-1:0] pstart_eff = wreg_q[IDX_PERF][NUM_CH-1:0] & ACT_P_OK;
   wire logic [NUM_CH-1:0] pstop_eff =
      wreg_q[IDX_PERF][PERF_STOP_LSB +: NUM_CH] & ACT_P_OK;
   wire logic [NUM_CH*PRED_W-1:0] pred_all = {wreg_q[IDX_PRED_HI][15:0], wreg_q[IDX_PRED_LO]};
   wire logic [NUM_CH*FACT_W-1:0] fact_all = wreg_q[IDX_FLAG_ACT][NUM_CH*FACT_W-1:0];

   // count conditions
   sbeu_qual_if qif ();
   wire logic halt_any;
   wire logic [NUM_CH-1:0] hit;
   assign qif.raw = ch_match;
   assign qif.clear = halt_any;
   for (g = 0; g < NUM_CH; g++) begin : g_tgt
      if (g == CNT_CH_A) begin : g_a
         assign qif.target[g] = wreg_q[IDX_COUNT][CNT_W-1:0];
      end else if (g == CNT_CH_B) begin : g_b
         assign qif.target[g] = wreg_q[IDX_COUNT][COUNT_CH11_LSB +: CNT_W];
      end else begin : g_none
         assign qif.target[g] = '0;
      end
   end
   assign hit = qif.hit;

   sbeu_count_unit u_count (
      .aclk(aclk),
      .aresetn(aresetn),
      .q(qif)
   );

   // fixed processor chains; the chain break does not depend on the break enables of the listed channels
   wire logic cpu_fixed = (cpu_mode != CPU_MODE_OFF) && (cpu_mode <= CPU_MODE_LAST_FIXED);
   wire logic [31:0] seq_tab = cpu_fixed ? CPU_SEQ_TAB[cpu_mode] : 32'h0000_0000;
   wire logic [3:0] seq_len = CPU_SEQ_LEN[cpu_mode];
   wire logic [NUM_CH-1:0] cpu_members = sbeu_members(seq_tab);
   wire logic [3:0] exp_ch = seq_tab[stage_reg[2:0]*4 +: 4];
   wire logic [NUM_CH:0] hit_ext = {hit, 1'b0};
   wire logic exp_hit = cpu_fixed && hit_ext[exp_ch];
   // only the expected stage advances, so nothing can be skipped
   wire logic cpu_done = exp_hit && (stage_reg == seq_len - 4'h1);

   always_comb begin
      stage_next = stage_reg;
      if (halt_any || ctrl_written || !cpu_fixed) begin
         stage_next = 4'h0;
      end else if (exp_hit) begin
         stage_next = stage_reg + 4'h1;
      end
   end

   // fixed system bus pairs
   wire logic sys_fixed = (sys_mode == SYS_9_THEN_8) || (sys_mode == SYS_8_THEN_9);
   wire logic sys_free = (sys_mode == SYS_FREE);
   wire logic sys_first = (sys_mode == SYS_9_THEN_8) ? hit[SYS_CH9] : hit[SYS_CH8];
   wire logic sys_second = (sys_mode == SYS_9_THEN_8) ? hit[SYS_CH8] : hit[SYS_CH9];
   wire logic sys_done = sys_fixed && sys_armed_reg && sys_second;
   wire logic [NUM_CH-1:0] sys_members = sys_fixed ? SYS_CH_MASK : '0;

   always_comb begin
      sys_armed_next = sys_armed_reg;
      if (halt_any || ctrl_written || !sys_fixed) begin
         sys_armed_next = 1'b0;
      end else if (sys_first) begin
         sys_armed_next = 1'b1;
      end
   end

   // free sequencing through predecessor selects
   wire logic cpu_free = (cpu_mode == CPU_MODE_FREE);
   wire logic [NUM_CH-1:0] free_ch =
      ({NUM_CH{cpu_free}} & CPU_CH_MASK) | ({NUM_CH{sys_free}} & SYS_CH_MASK);
   wire logic [15:0] pred_ok_vec = {flag_reg, 2'b00, seen_reg, 1'b1};
   wire logic [NUM_CH-1:0] sat;
   wire logic [NUM_CH-1:0] is_pred;
   wire logic [NUM_CH-1:0] fset;
   wire logic [NUM_CH-1:0] fclr;
   for (g = 0; g < NUM_CH; g++) begin : g_free
      wire logic [PRED_W-1:0] psel = pred_all[g*PRED_W +: PRED_W];
      wire logic [FACT_W-1:0] fact = fact_all[g*FACT_W +: FACT_W];
      wire logic [NUM_CH-1:0] named_by;
      assign sat[g] = hit[g] && free_ch[g] && pred_ok_vec[psel];
      assign fset[g] = sat[g] && (fact == FACT_SET);
      assign fclr[g] = sat[g] && (fact == FACT_CLR);
      for (j = 0; j < NUM_CH; j++) begin : g_by
         assign named_by[j] = free_ch[j] && (pred_all[j*PRED_W +: PRED_W] == PRED_W'(g + 1));
      end
      assign is_pred[g] = |named_by;
   end

   // progress and the shared flag start over after every break
   always_comb begin
      seen_next = halt_any ? '0 : (seen_reg | sat);
      flag_next = flag_reg;
      if (halt_any) begin
         flag_next = FLAG_INIT;
      end else if (|fset) begin
         flag_next = 1'b1;
      end else if (|fclr) begin
         flag_next = 1'b0;
      end
   end

   // break decision
   wire logic [NUM_CH-1:0] free_brk = sat & brk_eff & ~is_pred;
   wire logic [NUM_CH-1:0] indep_brk =
      hit & brk_eff & ~free_ch & ~cpu_members & ~sys_members;
   wire logic brk_now = cpu_done || sys_done || (|free_brk) || (|indep_brk);
   assign halt_any = brk_now || core_halt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_reg <= 4'h0;
         sys_armed_reg <= 1'b0;
         seen_reg <= '0;
         flag_reg <= FLAG_INIT;
      end else begin
         stage_reg <= stage_next;
         sys_armed_reg <= sys_armed_next;
         seen_reg <= seen_next;
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brk_reg <= 1'b0;
         trace_reg <= '0;
         perf_start_reg <= 1'b0;
         perf_stop_reg <= 1'b0;
      end else begin
         brk_reg <= brk_now;
         trace_reg <= hit & trc_eff;
         perf_start_reg <= |(hit & pstart_eff);
         perf_stop_reg <= |(hit & pstop_eff);
      end
   end
   assign brk_req = brk_reg;
   assign trace_req = trace_reg;
   assign perf_start = perf_start_reg;
   assign perf_stop = perf_stop_reg;

   // read path
   wire logic [31:0] status_word = {7'h00, sys_armed_reg, stage_reg, 3'h0, flag_reg,
      4'h0, seen_reg};
   wire logic rd_cfg = (s_axi_araddr[ADDR_W-1:2] < OFS_STATUS[ADDR_W-1:2]);
   wire logic rd_stat = (s_axi_araddr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]);
   wire logic [31:0] rd_word = rd_cfg ? wreg_q[s_axi_araddr[4:2]]
                             : (rd_stat ? status_word : 32'h0000_0000);
   assign s_axi_arready = !rvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= (rd_cfg || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule // sbeu_top
`default_nettype wire

// file: tb/sbeu_event_src.sv
// sbeu_event_src: comparator model giving one-cycle channel match pulses
`timescale 1ns/1ps
`default_nettype none
module sbeu_event_src import sbeu_pkg::*; (
   // clock
   input wire logic aclk,
   // comparator matches
   output logic [NUM_CH-1:0] ch_match
);
   initial begin
      ch_match = '0;
   end
   // pulses whatever channels it is given, whether the host has set them up or not
   task automatic fire(input logic [NUM_CH-1:0] m);
      @(posedge aclk);
      ch_match <= m;
      @(posedge aclk);
      ch_match <= '0;
      repeat (2) @(posedge aclk);
   endtask
endmodule // sbeu_event_src
`default_nettype wire

// file: tb/sbeu_top_asserts.sv
// sbeu_top_asserts: port-level checks of the event unit
`timescale 1ns/1ps
`default_nettype none
module sbeu_top_asserts import sbeu_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // events and actions
   input wire logic [NUM_CH-1:0] ch_match,
   input wire logic brk_req,
   input wire logic [NUM_CH-1:0] trace_req,
   input wire logic perf_start,
   input wire logic perf_stop,
   // bus responses
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_CH7_BREAK: assert property (ch_match[6] |=> brk_req)
      else $error("fixed break channel gave no break");
   AST_BRK_CAUSE: assert property (brk_req |-> $past(ch_match) != '0)
      else $error("break without a match one cycle before");
   AST_TRC_CAUSE: assert property ((trace_req & ~$past(ch_match)) == '0)
      else $error("trace request without its channel match");
   AST_TRC_CAPS: assert property ((trace_req & ~ACT_T_OK) == '0)
      else $error("trace request on a channel without trace action");
   AST_PSTART: assert property (perf_start |-> ($past(ch_match) & ACT_P_OK) != '0)
      else $error("perf start without a capable match");
   AST_PSTOP: assert property (perf_stop |-> ($past(ch_match) & ACT_P_OK) != '0)
      else $error("perf stop without a capable match");
   // responses must not drift while the host stalls
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed before bready");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed before rready");
endmodule // sbeu_top_asserts

bind sbeu_top sbeu_top_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
   .ch_match(ch_match), .brk_req(brk_req), .trace_req(trace_req),
   .perf_start(perf_start), .perf_stop(perf_stop), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// file: tb/tb_sbeu_top.sv
// tb_sbeu_top: self-checking bench for the sequential break and event unit
`timescale 1ns/1ps
`default_nettype none
module tb_sbeu_top import sbeu_pkg::*;;
   logic aclk, aresetn, core_halt;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, brk_req, perf_start, perf_stop;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
   logic [NUM_CH-1:0] ch_match, trace_req, trc_or;
   int fail_count, checks_done, brk_n, ps_n, pe_n, cyc;

   sbeu_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ch_match(ch_match), .core_halt(core_halt),
      .brk_req(brk_req), .trace_req(trace_req), .perf_start(perf_start),
      .perf_stop(perf_stop));
   sbeu_event_src u_src (.aclk(aclk), .ch_match(ch_match));

   initial begin
      aclk = 1'b0;
   end
   always #25 aclk = ~aclk;

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (brk_req === 1'b1) brk_n <= brk_n + 1;
      if (perf_start === 1'b1) ps_n <= ps_n + 1;
      if (perf_stop === 1'b1) pe_n <= pe_n + 1;
      trc_or <= trc_or | trace_req;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ready raised only after valid, so the hold window is exercised
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      wr_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic halt();
      @(posedge aclk);
      core_halt <= 1'b1;
      @(posedge aclk);
      core_halt <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   // mode register written last; a halt then flushes any stale progress
   task automatic cfg(input logic [31:0] c, b, pl, ph, fa, cn);
      logic [31:0] v [8];
      v = '{c, b, '0, '0, pl, ph, fa, cn};
      for (int i = 1; i <= 8; i++) wr(ADDR_W'((i % 8) * 4), v[i % 8]);
      halt();
   endtask

   task automatic t_reg();
      rd(OFS_CTRL);
      chk("ctrl reset", 32'h0, rd_d);
      wr(OFS_CTRL, 32'hFFFF_FFFF);
      rd(OFS_CTRL);
      chk("ctrl mask", 32'h0000_003F, rd_d);
      s_axi_wstrb <= 4'h1;
      wr(OFS_PERF, 32'hFFFF_FFFF);
      s_axi_wstrb <= 4'hF;
      rd(OFS_PERF);
      chk("strobe", 32'h0000_00FF, rd_d);
      wr(8'h24, 32'h0);
      chk("unmapped write resp", 32'h2, 32'(wr_r));
      rd(8'h24);
      chk("unmapped read resp", 32'h2, 32'(rd_r));
      $display("register test done");
   endtask

   task automatic t_pair(input logic [31:0] c, input logic [NUM_CH-1:0] a, b);
      int b0;
      cfg(c, 32'(a | b), '0, '0, '0, '0);
      b0 = brk_n;
      u_src.fire(b);
      u_src.fire(a);
      halt();
      u_src.fire(b);
      chk("pair wrong order or flushed", 32'h0, 32'(brk_n - b0));
      u_src.fire(a);
      u_src.fire(b);
      chk("pair in order", 32'h1, 32'(brk_n - b0));
      $display("pair test done, ctrl %h", c);
   endtask

   task automatic t_chain(input int m);
      logic [NUM_CH-1:0] lst [8];
      logic [NUM_CH-1:0] all;
      int l, b0;
      lst = '{12'h400, 12'h200, 12'h020, 12'h010, 12'h008, 12'h004, 12'h002, 12'h001};
      l = m - 2;
      all = '0;
      for (int k = 8 - l; k < 8; k++) all |= lst[k];
      cfg(32'(m), 32'(all), '0, '0, '0, '0);
      b0 = brk_n;
      u_src.fire(lst[8 - l]);
      for (int k = 10 - l; k < 8; k++) u_src.fire(lst[k]);
      chk("chain stage skipped", 32'h0, 32'(brk_n - b0));
      for (int k = 9 - l; k < 8; k++) u_src.fire(lst[k]);
      chk("chain in order", 32'h1, 32'(brk_n - b0));
      $display("chain test done, mode %0d", m);
   endtask

   task automatic t_free();
      int b0;
      cfg(32'h3B, 32'h018B, 32'h0000_F002, 32'h8, 32'h24, '0);
      b0 = brk_n;
      u_src.fire(12'h001);
      u_src.fire(12'h002);
      rd(OFS_STATUS);
      chk("flag after set", 32'h1, 32'(rd_d[STAT_FLAG_BIT]));
      chk("predecessor gating", 32'h0, 32'(brk_n - b0));
      u_src.fire(12'h001);
      rd(OFS_STATUS);
      chk("flag after break", 32'h0, 32'(rd_d[STAT_FLAG_BIT]));
      u_src.fire(12'h002);
      u_src.fire(12'h004);
      u_src.fire(12'h008);
      u_src.fire(12'h002);
      u_src.fire(12'h008);
      chk("cpu free breaks", 32'h2, 32'(brk_n - b0));
      u_src.fire(12'h100);
      u_src.fire(12'h080);
      u_src.fire(12'h100);
      chk("sys free breaks", 32'h3, 32'(brk_n - b0));
      $display("free sequence test done");
   endtask

   task automatic t_count();
      int b0;
      cfg('0, 32'h0402, '0, '0, '0, 32'h0002_0003);
      b0 = brk_n;
      repeat (2) u_src.fire(12'h002);
      chk("count not reached", 32'h0, 32'(brk_n - b0));
      u_src.fire(12'h002);
      u_src.fire(12'h400);
      u_src.fire(12'h400);
      chk("count reached", 32'h2, 32'(brk_n - b0));
      $display("count test done");
   endtask

   task automatic t_act();
      int b0, s0, e0;
      cfg('0, '0, '0, '0, '0, '0);
      wr(OFS_TRC_EN, 32'h0FFF);
      wr(OFS_PERF, 32'h0004_0001);
      b0 = brk_n;
      s0 = ps_n;
      e0 = pe_n;
      @(negedge aclk);
      trc_or = '0;
      u_src.fire(12'hFFF);
      chk("trace channels", 32'h09B0, 32'(trc_or));
      chk("fixed break", 32'h1, 32'(brk_n - b0));
      chk("perf start", 32'h1, 32'(ps_n - s0));
      chk("perf stop", 32'h1, 32'(pe_n - e0));
      $display("action test done");
   endtask

   initial begin
      aresetn = 1'b0;
      core_halt = 1'b0;
      s_axi_awaddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      {fail_count, checks_done, brk_n, ps_n, pe_n, cyc} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reg();
      t_pair(32'h1, 12'h002, 12'h001);
      t_pair(32'h2, 12'h008, 12'h004);
      t_pair(32'h3, 12'h020, 12'h010);
      t_pair(32'h4, 12'h400, 12'h200);
      t_pair(32'h10, 12'h100, 12'h080);
      t_pair(32'h20, 12'h080, 12'h100);
      for (int m = 5; m <= 10; m++) t_chain(m);
      t_free();
      t_count();
      t_act();
      print_verdict();
   end
endmodule // tb_sbeu_top
`default_nettype wire
